// ---- verification/bie_exec_props.sv ----
/* checker for bie_exec: jump, increment and skip output timing.
   assumes binding to bie_exec and a view of its ports only. */
`default_nettype none
module bie_exec_props (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        clk_en,
    input wire logic        instr_valid,
    input wire logic [11:0] instr_word,
    input wire logic [7:0]  status_in,
    input wire logic [7:0]  file_rd_data,
    input wire logic        file_wr_en,
    input wire logic [7:0]  file_wr_data,
    input wire logic        work_wr_en,
    input wire logic [7:0]  work_wr_data,
    input wire logic        zero_wr_en,
    input wire logic        zero_value,
    input wire logic        pc_load,
    input wire logic [10:0] program_counter,
    input wire logic        flush,
    input wire logic        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    logic        take, jmp, increment_file, incs, dst;
    logic [7:0]  sum;
    logic [10:0] tgt;
    assign take = clk_en && instr_valid && !busy;
    assign jmp  = (instr_word & 12'hE00) == 12'hA00;
    assign increment_file = (instr_word & 12'hFC0) == 12'h280;
    assign incs = (instr_word & 12'hFC0) == 12'h3C0;
    assign dst  = instr_word[5];
    assign sum  = file_rd_data + 8'h01;
    assign tgt  = {status_in[6:5], instr_word[8:0]};
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    chk_jump_taken: assert property (
        take && jmp |=> pc_load && !zero_wr_en)
        else $error("jump load missing");
    chk_jump_target: assert property (
        take && jmp |=> program_counter == $past(tgt))
        else $error("jump target wrong");
    chk_jump_flush: assert property (
        take && jmp |-> flush)
        else $error("jump flush missing");
    chk_kill_busy: assert property (
        take && (jmp || incs && sum == 8'h00) |=> busy)
        else $error("second cycle missing");
    chk_skip_single: assert property (
        take && incs && sum != 8'h00 |=> !busy)
        else $error("nonzero skip took two cycles");
    chk_inc_route: assert property (
        take && (increment_file || incs)
        |=> file_wr_en == $past(dst) && work_wr_en != $past(dst))
        else $error("destination wrong");
    chk_inc_sum: assert property (
        take && (increment_file || incs)
        |=> (file_wr_en ? file_wr_data : work_wr_data) == $past(sum))
        else $error("sum wrong");
    chk_inc_zero: assert property (
        take && increment_file
        |=> zero_wr_en && zero_value == ($past(sum) == 8'h00))
        else $error("zero flag wrong");
    chk_skip_noflag: assert property (
        take && incs |=> !zero_wr_en)
        else $error("skip wrote flag");
    chk_skip_flush: assert property (
        take && incs |-> flush == (sum == 8'h00))
        else $error("skip flush wrong");
    chk_killed_slot: assert property (
        busy && clk_en && instr_valid
        |-> !flush ##1 !(pc_load || file_wr_en || work_wr_en || zero_wr_en))
        else $error("killed slot acted");
    // a low enable must hold program_counter and pc_load
    chk_enable_freeze: assert property (
        !clk_en |=> $stable(program_counter) && $stable(pc_load))
        else $error("state moved while enable low");
    cover property (take && jmp);
    cover property (take && incs && sum == 8'h00);
    cover property (take && increment_file && sum == 8'h00);
endmodule : bie_exec_props
bind bie_exec bie_exec_props u_props (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .instr_valid(instr_valid), .instr_word(instr_word),
    .status_in(status_in), .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .work_wr_en(work_wr_en), .work_wr_data(work_wr_data),
    .zero_wr_en(zero_wr_en), .zero_value(zero_value), .pc_load(pc_load),
    .program_counter(program_counter), .flush(flush), .busy(busy));
`default_nettype wire

// ---- verification/tb_bie_exec.sv ----
/* bench for bie_exec: jumps, increments and skips with killed slots.
   assumes the bench models the file read port and status directly. */
`default_nettype none
module tb_bie_exec;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and checks
    // ------------------------------------------------------------
    logic        clk, sys_rst, clk_en, instr_valid, fl, d, z;
    logic        file_wr_en, work_wr_en, zero_wr_en, zero_value;
    logic        pc_load, flush, busy;
    logic [11:0] instr_word;
    logic [7:0]  status_in, file_rd_data, file_wr_data, work_wr_data, v, e8;
    logic [4:0]  file_rd_addr, file_wr_addr, fa;
    logic [10:0] program_counter;
    logic [8:0]  k;
    int          error_cnt = 0;
    int          tests_run = 0;
    bie_exec dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .status_in(status_in), .file_rd_data(file_rd_data),
        .file_rd_addr(file_rd_addr), .file_wr_en(file_wr_en),
        .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
        .work_wr_en(work_wr_en), .work_wr_data(work_wr_data),
        .zero_wr_en(zero_wr_en), .zero_value(zero_value), .pc_load(pc_load),
        .program_counter(program_counter), .flush(flush), .busy(busy));
    always #5 clk = ~clk;
    task automatic chk(input logic [10:0] g, input logic [10:0] e);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk
    // flush is combinational, so it is sampled before the taking edge
    task automatic step(input logic [11:0] w, input logic [7:0] r, s);
        instr_word = w;
        file_rd_data = r;
        status_in = s;
        instr_valid = 1'b1;
        #1;
        fl = flush;
        @(negedge clk);
    endtask : step
    task automatic finish_test;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        error_cnt++;
        finish_test();
    end
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        instr_valid = 1'b0;
        instr_word = 12'h000;
        file_rd_data = 8'h00;
        status_in = 8'h00;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        for (int p = 0; p < 4; p++) begin
            k = p[0] ? 9'h1FF : 9'h0A5;
            step({3'h5, k}, 8'h00, {1'b1, p[1:0], 5'h1F});
            chk(fl, 1'b1);
            chk(pc_load, 1'b1);
            chk(program_counter, {p[1:0], k});
            chk(zero_wr_en, 1'b0);
            chk(busy, 1'b1);
            step(12'h3E3, 8'hFF, 8'h00);
            chk(fl, 1'b0);
            chk(file_wr_en, 1'b0);
            chk(busy, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            d = i[0];
            v = i[1] ? 8'hFF : (i[2] ? 8'h10 : 8'h7F);
            e8 = v + 8'h01;
            z = e8 == 8'h00;
            fa = 5'h11 + i[4:0];
            step({i[2] ? 6'h0F : 6'h0A, d, fa}, v, 8'h00);
            chk(file_rd_addr, fa);
            chk(file_wr_addr, fa);
            chk(file_wr_en, d);
            chk(work_wr_en, !d);
            chk(d ? file_wr_data : work_wr_data, e8);
            chk(zero_wr_en, !i[2]);
            chk(fl, i[2] && z);
            chk(busy, i[2] && z);
            if (!i[2]) chk(zero_value, z);
            step(12'hA05, 8'h00, 8'h00);
            chk(fl, !(i[2] && z));
            chk(pc_load, !(i[2] && z));
            step(12'h000, 8'h00, 8'h00);
        end
        clk_en = 1'b0;
        step(12'hA12, 8'h00, 8'h60);
        chk(pc_load, 1'b0);
        chk(program_counter, 11'h005);
        chk(busy, 1'b0);
        clk_en = 1'b1;
        step(12'hA12, 8'h00, 8'h60);
        chk(pc_load, 1'b1);
        chk(program_counter, 11'h612);
        chk(busy, 1'b1);
        step(12'h000, 8'h00, 8'h00);
        chk(busy, 1'b0);
        finish_test();
    end
endmodule : tb_bie_exec
`default_nettype wire

// ---- verilog/bie_decode.sv ----
/*
 * opcode classifier: sorts one instruction word into the handled classes.
 * assumes the word is stable for the cycle in which it is presented.
 */
`default_nettype none

module bie_decode (
    input  wire logic [11:0]    opcode,
    output var bie_pkg::bie_op_t op_class
);
    // ------------------------------------------------------------------
    // classification
    // ------------------------------------------------------------------
    function automatic bie_pkg::bie_op_t classify(input logic [11:0] w);
        if ((w & bie_pkg::JMP_MASK) == bie_pkg::JMP_CODE) begin // [RL1]
            return bie_pkg::BIE_OP_JUMP;
        end else if ((w & bie_pkg::INC_MASK) == bie_pkg::INC_CODE) begin
            return bie_pkg::BIE_OP_INC;
        end else if ((w & bie_pkg::INC_MASK) == bie_pkg::INCS_CODE) begin
            return bie_pkg::BIE_OP_INCS;
        end else begin
            return bie_pkg::BIE_OP_OTHER;
        end
    endfunction : classify

    assign op_class = classify(opcode);
endmodule : bie_decode

`default_nettype wire

// ---- verilog/bie_exec.sv ----
/*
 * execution logic for the absolute jump, the file increment and the
 * increment-and-skip instructions of a 12-bit-word core.
 * assumes the fetch unit presents one instruction word per enabled cycle
 * with a valid flag, and supplies the addressed file value combinationally.
 * file writes and status writes are one-cycle pulses with registered data.
 */
// Functional notes
// RL1: absolute jump decoded, always taken, no condition
// RL2: nine literal bits load counter bits 8..0
// RL3: status bits 6..5 load counter bits 10..9
// RL4: jump takes two cycles, flags untouched
// RL5: increment file, destination bit picks target
// RL6: increment-skip routes likewise, flags untouched
// RL7: zero result skips next, two cycles
// RL8: skipped slot runs as no-operation, no effect
// RL9: increment wraps, zero flag follows result
`default_nettype none

module bie_exec (
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          clk_en,
    input  wire logic          instr_valid,
    input  wire logic [11:0]   instr_word,
    input  wire logic [7:0]    status_in,
    input  wire logic [7:0]    file_rd_data,
    output logic      [4:0]    file_rd_addr,
    output logic               file_wr_en,
    output logic      [4:0]    file_wr_addr,
    output logic      [7:0]    file_wr_data,
    output logic               work_wr_en,
    output logic      [7:0]    work_wr_data,
    output logic               zero_wr_en,
    output logic               zero_value,
    output logic               pc_load,
    output logic      [10:0]   program_counter,
    output logic               flush,
    output logic               busy
);
    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    bie_pkg::bie_op_t op_class;
    logic             slot_dead;
    logic             live;
    logic [7:0]       sum;
    logic             dest_file;

    bie_decode u_decode (
        .opcode   (instr_word),
        .op_class (op_class)
    );

    // an instruction in a flushed slot is a no-operation
    assign live      = instr_valid && !slot_dead; // [RL8]
    assign file_rd_addr = instr_word[bie_pkg::FADR_HI:0];
    // eight-bit add drops the carry, so all ones wraps to zero
    assign sum       = file_rd_data + 8'h01; // [RL9]
    assign dest_file = instr_word[bie_pkg::DEST_BIT];

    // ------------------------------------------------------------------
    // slot kill: the word after a taken jump or zero skip is discarded
    // ------------------------------------------------------------------
    logic next_dead;

    always_comb begin
        next_dead = 1'b0;
        if (live) begin
            unique case (op_class)
                bie_pkg::BIE_OP_JUMP:  next_dead = 1'b1; // [RL4]
                bie_pkg::BIE_OP_INCS:  next_dead = (sum == 8'h00); // [RL7]
                bie_pkg::BIE_OP_INC:   next_dead = 1'b0;
                bie_pkg::BIE_OP_OTHER: next_dead = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_dead <= 1'b0;
        end else if (clk_en) begin
            if (instr_valid) begin
                slot_dead <= next_dead; // [RL8]
            end
        end
    end

    // combinational handshake: tells fetch to drop its prefetched word
    assign flush = live && next_dead; // [RL7] [RL8]
    // second cycle of a two-cycle instruction
    assign busy  = slot_dead; // [RL4] [RL7]

    // ------------------------------------------------------------------
    // program counter load
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_load         <= 1'b0;
            program_counter <= bie_pkg::PC_RST;
        end else if (clk_en) begin
            pc_load <= live && (op_class == bie_pkg::BIE_OP_JUMP); // [RL1]
            if (live && (op_class == bie_pkg::BIE_OP_JUMP)) begin
                program_counter <= {
                    status_in[bie_pkg::PAGE_HI:bie_pkg::PAGE_LO], // [RL3]
                    instr_word[bie_pkg::LIT_HI:0]                 // [RL2]
                };
            end
        end
    end

    // ------------------------------------------------------------------
    // result routing
    // ------------------------------------------------------------------
    logic is_inc;

    assign is_inc = live && ((op_class == bie_pkg::BIE_OP_INC)
                          || (op_class == bie_pkg::BIE_OP_INCS));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            file_wr_en   <= 1'b0;
            file_wr_addr <= 5'h00;
            file_wr_data <= bie_pkg::DATA_RST;
            work_wr_en   <= 1'b0;
            work_wr_data <= bie_pkg::DATA_RST;
        end else if (clk_en) begin
            file_wr_en <= is_inc && dest_file; // [RL5] [RL6]
            work_wr_en <= is_inc && !dest_file; // [RL5] [RL6]
            if (is_inc) begin
                file_wr_addr <= file_rd_addr;
                file_wr_data <= sum;
                work_wr_data <= sum;
            end
        end
    end

    // ------------------------------------------------------------------
    // zero flag: only the plain increment touches it
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            zero_wr_en <= 1'b0;
            zero_value <= 1'b0;
        end else if (clk_en) begin
            // jump and increment-skip leave the flags alone
            zero_wr_en <= live
                       && (op_class == bie_pkg::BIE_OP_INC); // [RL6] [RL9]
            if (live && (op_class == bie_pkg::BIE_OP_INC)) begin
                zero_value <= (sum == 8'h00); // [RL9]
            end
        end
    end
endmodule : bie_exec

`default_nettype wire

// ---- verilog/bie_pkg.sv ----
/*
 * constants for the branch and increment execution block: opcode patterns,
 * field positions, status bit positions and widths.
 * assumes a 12-bit instruction word and an 11-bit program counter.
 */
`default_nettype none

package bie_pkg;
    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int OP_W   = 12;
    localparam int PC_W   = 11;
    localparam int DATA_W = 8;
    localparam int FADR_W = 5;

    // ------------------------------------------------------------------
    // opcode patterns and masks
    // ------------------------------------------------------------------
    localparam logic [11:0] JMP_MASK  = 12'hE00;
    localparam logic [11:0] JMP_CODE  = 12'hA00;
    localparam logic [11:0] INC_MASK  = 12'hFC0;
    localparam logic [11:0] INC_CODE  = 12'h280;
    localparam logic [11:0] INCS_CODE = 12'h3C0;
    localparam logic [11:0] NOP_CODE  = 12'h000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LIT_HI   = 8;
    localparam int DEST_BIT = 5;
    localparam int FADR_HI  = 4;
    localparam int PAGE_LO  = 5;
    localparam int PAGE_HI  = 6;
    localparam int ZERO_BIT = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  DATA_RST = 8'h00;
    localparam logic [10:0] PC_RST   = 11'h000;
    localparam logic [11:0] OP_RST   = 12'h000;

    typedef enum logic [1:0] {
        BIE_OP_OTHER,
        BIE_OP_JUMP,
        BIE_OP_INC,
        BIE_OP_INCS
    } bie_op_t;
endpackage : bie_pkg

`default_nettype wire
